// ---- core/lsr_pkg.sv ----
// Constants and types for the light sensor serial register port
package lsr_pkg;

    // Bus address of the device
    localparam logic [6:0] DEV_ADDR = 7'h44;

    // Register offsets
    localparam logic [3:0] REG_OPERATION_CONTROL = 4'h0;
    localparam logic [3:0] REG_RANGE_RESOLUTION  = 4'h1;
    localparam logic [3:0] REG_RESULT_LOW        = 4'h2;
    localparam logic [3:0] REG_RESULT_HIGH       = 4'h3;
    localparam logic [3:0] REG_LOWER_THR_LOW     = 4'h4;
    localparam logic [3:0] REG_LOWER_THR_HIGH    = 4'h5;
    localparam logic [3:0] REG_UPPER_THR_LOW     = 4'h6;
    localparam logic [3:0] REG_UPPER_THR_HIGH    = 4'h7;
    localparam logic [3:0] REG_FACTORY_CHECK     = 4'h8;
    localparam logic [3:0] REG_LAST              = 4'h8;
    localparam int         REG_COUNT             = 9;

    // Reset values per offset
    localparam logic [7:0] REG_RESET [0:REG_COUNT-1] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
    // Bits that a bus write may change; reserved and status bits excluded
    localparam logic [7:0] REG_WMASK [0:REG_COUNT-1] = '{
        8'he3, 8'h0f, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};

    // Field positions
    localparam int FLAG_POS     = 2;
    localparam int MODE_MSB     = 7;
    localparam int MODE_LSB     = 5;
    localparam int PERSIST_MSB  = 1;
    localparam int WIDTH_MSB    = 3;
    localparam int WIDTH_LSB    = 2;
    localparam int SCALE_MSB    = 1;

    // Timing
    localparam int         CLK_NS       = 40;
    localparam int         POWERUP_NS   = 2000;
    localparam int         WCYC_NS      = 1000;
    localparam logic [7:0] BOOT_CYCLES  = 8'((POWERUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] WCYC_CYCLES  = 8'((WCYC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] BITS_BYTE    = 4'h8;
    localparam logic [3:0] TX_LAST_BIT  = 4'h7;

    // Serial engine states, Gray along the usual path
    typedef enum logic [3:0] {
        ST_BOOT = 4'b0000,
        ST_IDLE = 4'b0001,
        ST_ADDR = 4'b0011,
        ST_AACK = 4'b0010,
        ST_PTR  = 4'b0110,
        ST_PACK = 4'b0111,
        ST_WDAT = 4'b0101,
        ST_WACK = 4'b0100,
        ST_TX   = 4'b1100,
        ST_MACK = 4'b1101,
        ST_LOST = 4'b1111,
        ST_WCYC = 4'b1110
    } lsr_state_type;

endpackage

// ---- core/lsr_bit_sampler.sv ----
// Link-clock sampler: captures SDA on each rising SCL edge
`timescale 1ns/1ns
module lsr_bit_sampler (
    // Link clock and reset
    input  wire logic scl_clk,
    input  wire logic arst_n,
    // Serial data pin
    input  wire logic sda_in,
    // Captured bit, held until the next rising SCL edge
    output logic      bit_value,
    output logic      bit_toggle
);

    logic bit_reg;
    logic bit_next;
    logic tog_reg;
    logic tog_next;

    // Next sample and event toggle
    always_comb begin
        bit_next = sda_in;
        tog_next = ~tog_reg;
    end

    // Sample registers on the link clock
    always_ff @(posedge scl_clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_reg <= 1'b1;
            tog_reg <= 1'b0;
        end else begin
            bit_reg <= bit_next;
            tog_reg <= tog_next;
        end
    end

    assign bit_value  = bit_reg;
    assign bit_toggle = tog_reg;

endmodule

// ---- core/lsr_serial_port.sv ----
// Serial register port: bus slave engine and register map
`timescale 1ns/1ns
module lsr_serial_port (
    // Core clock and power-on reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Serial bus pins
    input  wire logic        scl_clk,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Conversion engine side
    input  wire logic        result_strobe,
    input  wire logic [15:0] result_value,
    input  wire logic        flag_raise,
    // Control fields to the conversion engine
    output logic [2:0]       mode_select,
    output logic [1:0]       persistence_sel,
    output logic [1:0]       conversion_width,
    output logic [1:0]       scale_sel,
    output logic [15:0]      lower_threshold,
    output logic [15:0]      upper_threshold,
    output logic             flag_status,
    output logic             port_busy
);

    // Synchronisers and crossing
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic tog_s1, tog_s2, tog_s3;
    logic link_bit;
    logic link_tog;
    logic start_ev, stop_ev, scl_fall, bit_ev;

    // Engine state
    lsr_pkg::lsr_state_type state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] ptr_reg, ptr_next;
    logic [3:0] last_reg, last_next;
    logic [3:0] txa_reg, txa_next;
    logic [7:0] wait_reg, wait_next;
    logic       oe_reg, oe_next;
    logic       rw_reg, rw_next;
    logic       wrote_reg, wrote_next;
    logic       wr_en;
    logic       flag_clr;
    logic [7:0] rd_byte;

    // Register array
    logic [7:0] regs_reg  [0:lsr_pkg::REG_COUNT-1];
    logic [7:0] regs_next [0:lsr_pkg::REG_COUNT-1];

    // Pointer step with wrap at the end of the map
    function automatic logic [3:0] step_ptr(input logic [3:0] p);
        step_ptr = (p == lsr_pkg::REG_LAST) ? 4'h0 : 4'(p + 4'h1);
    endfunction

    // Read a register; unmapped pointers read zero
    function automatic logic [7:0] read_reg(input logic [3:0] a);
        read_reg = (a <= lsr_pkg::REG_LAST) ? regs_reg[a] : 8'h00;
    endfunction

    // Link-clock sampler
    lsr_bit_sampler u_sampler (
        .scl_clk    (scl_clk),
        .arst_n     (arst_n),
        .sda_in     (sda_in),
        .bit_value  (link_bit),
        .bit_toggle (link_tog)
    );

    // Two-flop synchronisers plus an edge stage
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            {scl_s1, scl_s2, scl_s3} <= 3'b111;
            {sda_s1, sda_s2, sda_s3} <= 3'b111;
            {tog_s1, tog_s2, tog_s3} <= 3'b000;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
            {tog_s1, tog_s2, tog_s3} <= {link_tog, tog_s1, tog_s2};
        end
    end

    // Bus conditions seen in the core domain
    assign start_ev = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
    assign stop_ev  = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
    assign scl_fall = scl_s3 && !scl_s2;
    assign bit_ev   = tog_s2 ^ tog_s3;

    // Byte at the pointer, ready for the next transmit
    assign rd_byte = read_reg(ptr_reg);

    // Engine next state
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        ptr_next   = ptr_reg;
        last_next  = last_reg;
        txa_next   = txa_reg;
        wait_next  = wait_reg;
        oe_next    = oe_reg;
        rw_next    = rw_reg;
        wrote_next = wrote_reg;
        wr_en      = 1'b0;
        flag_clr   = 1'b0;
        case (state_reg)
            lsr_pkg::ST_BOOT: begin
                oe_next = 1'b0;
                if (wait_reg == 8'h00) begin
                    state_next = lsr_pkg::ST_IDLE;
                end else begin
                    wait_next = 8'(wait_reg - 8'h01);
                end
            end
            lsr_pkg::ST_ADDR, lsr_pkg::ST_PTR, lsr_pkg::ST_WDAT: begin
                if (bit_ev && cnt_reg != lsr_pkg::BITS_BYTE) begin
                    shift_next = {shift_reg[6:0], link_bit};
                    cnt_next   = 4'(cnt_reg + 4'h1);
                end
                if (scl_fall && cnt_reg == lsr_pkg::BITS_BYTE) begin
                    cnt_next = 4'h0;
                    oe_next  = 1'b1;
                    if (state_reg == lsr_pkg::ST_ADDR) begin
                        if (shift_reg[7:1] == lsr_pkg::DEV_ADDR) begin
                            state_next = lsr_pkg::ST_AACK;
                            rw_next    = shift_reg[0];
                        end else begin
                            state_next = lsr_pkg::ST_LOST;
                            oe_next    = 1'b0;
                        end
                    end else if (state_reg == lsr_pkg::ST_PTR) begin
                        state_next = lsr_pkg::ST_PACK;
                    end else begin
                        state_next = lsr_pkg::ST_WACK;
                    end
                end
            end
            lsr_pkg::ST_AACK: begin
                if (scl_fall) begin
                    if (rw_reg) begin
                        state_next = lsr_pkg::ST_TX;
                        shift_next = rd_byte;
                        txa_next   = ptr_reg;
                        oe_next    = ~rd_byte[7];
                    end else begin
                        state_next = lsr_pkg::ST_PTR;
                        oe_next    = 1'b0;
                    end
                end
            end
            lsr_pkg::ST_PACK: begin
                if (scl_fall) begin
                    state_next = lsr_pkg::ST_WDAT;
                    oe_next    = 1'b0;
                    ptr_next   = (shift_reg > {4'h0, lsr_pkg::REG_LAST}) ? 4'h0 : shift_reg[3:0];
                end
            end
            lsr_pkg::ST_WACK: begin
                if (scl_fall) begin
                    state_next = lsr_pkg::ST_WDAT;
                    oe_next    = 1'b0;
                    wr_en      = 1'b1;
                    last_next  = ptr_reg;
                    ptr_next   = step_ptr(ptr_reg);
                    wrote_next = 1'b1;
                end
            end
            lsr_pkg::ST_TX: begin
                if (scl_fall) begin
                    if (cnt_reg == lsr_pkg::TX_LAST_BIT) begin
                        state_next = lsr_pkg::ST_MACK;
                        cnt_next   = 4'h0;
                        oe_next    = 1'b0;
                        flag_clr   = (txa_reg == lsr_pkg::REG_OPERATION_CONTROL);
                        ptr_next   = step_ptr(ptr_reg);
                    end else begin
                        cnt_next   = 4'(cnt_reg + 4'h1);
                        shift_next = {shift_reg[6:0], 1'b0};
                        oe_next    = ~shift_reg[6];
                    end
                end
            end
            lsr_pkg::ST_MACK: begin
                if (bit_ev) begin
                    shift_next[0] = link_bit;
                end
                if (scl_fall) begin
                    if (!shift_reg[0]) begin
                        state_next = lsr_pkg::ST_TX;
                        shift_next = rd_byte;
                        txa_next   = ptr_reg;
                        oe_next    = ~rd_byte[7];
                    end else begin
                        state_next = lsr_pkg::ST_LOST;
                    end
                end
            end
            lsr_pkg::ST_WCYC: begin
                oe_next = 1'b0;
                if (wait_reg == 8'h00) begin
                    state_next = lsr_pkg::ST_IDLE;
                end else begin
                    wait_next = 8'(wait_reg - 8'h01);
                end
            end
            lsr_pkg::ST_IDLE, lsr_pkg::ST_LOST: begin
                oe_next = 1'b0;
            end
            default: begin
                state_next = lsr_pkg::ST_IDLE;
                oe_next    = 1'b0;
            end
        endcase
        // Bus conditions override, except during power-up and write cycle
        if (state_reg != lsr_pkg::ST_BOOT && state_reg != lsr_pkg::ST_WCYC) begin
            if (stop_ev) begin
                oe_next    = 1'b0;
                cnt_next   = 4'h0;
                wr_en      = 1'b0;
                if (wrote_reg) begin
                    state_next = lsr_pkg::ST_WCYC;
                    wait_next  = 8'(lsr_pkg::WCYC_CYCLES - 8'h01);
                    ptr_next   = last_reg;
                    wrote_next = 1'b0;
                end else begin
                    state_next = lsr_pkg::ST_IDLE;
                end
            end else if (start_ev) begin
                state_next = lsr_pkg::ST_ADDR;
                cnt_next   = 4'h0;
                oe_next    = 1'b0;
                wr_en      = 1'b0;
            end
        end
    end

    // Engine registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= lsr_pkg::ST_BOOT;
            cnt_reg   <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg   <= 4'h0;
            last_reg  <= 4'h0;
            txa_reg   <= 4'h0;
            wait_reg  <= lsr_pkg::BOOT_CYCLES;
            oe_reg    <= 1'b0;
            rw_reg    <= 1'b0;
            wrote_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
            ptr_reg   <= ptr_next;
            last_reg  <= last_next;
            txa_reg   <= txa_next;
            wait_reg  <= wait_next;
            oe_reg    <= oe_next;
            rw_reg    <= rw_next;
            wrote_reg <= wrote_next;
        end
    end

    // Register map next values
    always_comb begin
        for (int i = 0; i < lsr_pkg::REG_COUNT; i++) begin
            regs_next[i] = regs_reg[i];
        end
        if (wr_en && ptr_reg <= lsr_pkg::REG_LAST) begin
            regs_next[ptr_reg] = (regs_reg[ptr_reg] & ~lsr_pkg::REG_WMASK[ptr_reg])
                               | (shift_reg & lsr_pkg::REG_WMASK[ptr_reg]);
        end
        if (result_strobe) begin
            regs_next[lsr_pkg::REG_RESULT_LOW]  = result_value[7:0];
            regs_next[lsr_pkg::REG_RESULT_HIGH] = result_value[15:8];
        end
        // Read of the control byte clears the flag; a new raise wins
        if (flag_clr) begin
            regs_next[lsr_pkg::REG_OPERATION_CONTROL][lsr_pkg::FLAG_POS] = 1'b0;
        end
        if (flag_raise) begin
            regs_next[lsr_pkg::REG_OPERATION_CONTROL][lsr_pkg::FLAG_POS] = 1'b1;
        end
    end

    // Register map storage
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < lsr_pkg::REG_COUNT; i++) begin
                regs_reg[i] <= lsr_pkg::REG_RESET[i];
            end
        end else begin
            for (int i = 0; i < lsr_pkg::REG_COUNT; i++) begin
                regs_reg[i] <= regs_next[i];
            end
        end
    end

    // Pin and field outputs
    assign sda_out          = 1'b0;
    assign sda_oe           = oe_reg;
    assign port_busy        = (state_reg == lsr_pkg::ST_WCYC) || (state_reg == lsr_pkg::ST_BOOT);
    assign mode_select      = regs_reg[0][lsr_pkg::MODE_MSB:lsr_pkg::MODE_LSB];
    assign persistence_sel  = regs_reg[0][lsr_pkg::PERSIST_MSB:0];
    assign flag_status      = regs_reg[0][lsr_pkg::FLAG_POS];
    assign conversion_width = regs_reg[1][lsr_pkg::WIDTH_MSB:lsr_pkg::WIDTH_LSB];
    assign scale_sel        = regs_reg[1][lsr_pkg::SCALE_MSB:0];
    assign lower_threshold  = {regs_reg[5], regs_reg[4]};
    assign upper_threshold  = {regs_reg[7], regs_reg[6]};

    // Checks on the engine
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_write_stop;
        stop_ev && wrote_reg && state_reg != lsr_pkg::ST_WCYC && state_reg != lsr_pkg::ST_BOOT;
    endsequence

    sequence s_quiet_cycle;
        (state_reg == lsr_pkg::ST_WCYC && !oe_reg) [*8];
    endsequence

    addr_match_a: assert property (
        state_reg == lsr_pkg::ST_AACK |-> shift_reg[7:1] == lsr_pkg::DEV_ADDR && oe_reg)
        else $error("acknowledge given to a foreign bus address");
    write_cycle_a: assert property (s_write_stop |=> s_quiet_cycle)
        else $error("write cycle not entered quietly after stop");
    ack_drive_a: assert property (
        (state_reg inside {lsr_pkg::ST_PACK, lsr_pkg::ST_WACK}) |-> oe_reg)
        else $error("byte not acknowledged");
    ptr_wrap_a: assert property (
        state_reg == lsr_pkg::ST_WACK && scl_fall && !stop_ev && !start_ev
        && ptr_reg == lsr_pkg::REG_LAST |=> ptr_reg == 4'h0)
        else $error("pointer did not wrap");
    ptr_step_a: assert property (
        state_reg == lsr_pkg::ST_WACK && scl_fall && !stop_ev && !start_ev
        && ptr_reg < lsr_pkg::REG_LAST |=> ptr_reg == $past(ptr_reg) + 4'h1)
        else $error("pointer did not step after a write");
    ptr_hold_a: assert property (s_write_stop |=> ptr_reg == $past(last_reg))
        else $error("pointer not left at last written location");
    result_keep_a: assert property (
        wr_en && ptr_reg == lsr_pkg::REG_RESULT_LOW && !result_strobe
        |=> $stable(regs_reg[lsr_pkg::REG_RESULT_LOW]))
        else $error("result register changed by a bus write");
    factory_keep_a: assert property (
        wr_en && ptr_reg == lsr_pkg::REG_FACTORY_CHECK
        |=> $stable(regs_reg[lsr_pkg::REG_FACTORY_CHECK]))
        else $error("test location changed by a bus write");
    msb_first_a: assert property (
        state_reg == lsr_pkg::ST_AACK && rw_reg && scl_fall && !stop_ev && !start_ev
        |=> oe_reg == ~shift_reg[7] && cnt_reg == 4'h0)
        else $error("read byte does not start with its top bit");
    nack_release_a: assert property (
        state_reg == lsr_pkg::ST_MACK && scl_fall && shift_reg[0] && !stop_ev && !start_ev
        |=> state_reg == lsr_pkg::ST_LOST ##1 !oe_reg)
        else $error("still driving after master withheld acknowledge");
    stop_drop_a: assert property (
        stop_ev && !wrote_reg && state_reg inside {lsr_pkg::ST_WDAT, lsr_pkg::ST_WACK}
        |-> !wr_en ##1 state_reg == lsr_pkg::ST_IDLE && !oe_reg)
        else $error("access performed after an early stop");
    boot_deaf_a: assert property (
        state_reg == lsr_pkg::ST_BOOT && start_ev |=> state_reg != lsr_pkg::ST_ADDR && !oe_reg)
        else $error("start accepted during power-up");

endmodule

// ---- bench/lsr_i2c_master.sv ----
// Bus master model that drives SCL and pulls SDA through tasks
`timescale 1ns/1ns
module lsr_i2c_master (
    // Bus pins, SDA as open drain
    output logic      scl,
    output logic      sda_oe,
    input  wire logic sda
);
    localparam int HALF_NS = 240;
    // SCL stands high outside frames
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // One bit, changed only while SCL is low
    task automatic put_bit(input logic b);
        sda_oe = ~b;
        #(HALF_NS / 2) scl = 1'b1;
        #HALF_NS scl = 1'b0;
        #(HALF_NS / 2);
    endtask
    // Released SDA sampled mid-high
    task automatic get_bit(output logic b);
        sda_oe = 1'b0;
        #(HALF_NS / 2) scl = 1'b1;
        #(HALF_NS / 2) b = sda;
        #(HALF_NS / 2) scl = 1'b0;
        #(HALF_NS / 2);
    endtask
    // START or repeated START
    task automatic start();
        sda_oe = 1'b0;
        #(HALF_NS / 2) scl = 1'b1;
        #HALF_NS sda_oe = 1'b1;
        #HALF_NS scl = 1'b0;
        #(HALF_NS / 2);
    endtask
    // STOP, then SDA back to the pull-up
    task automatic stop();
        sda_oe = 1'b1;
        #(HALF_NS / 2) scl = 1'b1;
        #HALF_NS sda_oe = 1'b0;
        #HALF_NS;
    endtask
    // Byte out MSB first, acknowledge taken in the ninth clock
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(b);
        ack = (b === 1'b0);
    endtask
    // Byte in, acknowledged only when more is wanted
    task automatic rbyte(output logic [7:0] d, input logic more);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(~more);
    endtask
endmodule

// ---- bench/tb_top.sv ----
// Testbench for the light sensor serial register port
`timescale 1ns/1ns
module tb_top;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        result_strobe = 1'b0;
    logic [15:0] result_value = 16'h0000;
    logic        flag_raise = 1'b0;
    wire         scl;
    wire         m_oe;
    wire         sda;
    logic        sda_out, sda_oe, flag_status, port_busy;
    logic [2:0]  mode_select;
    logic [1:0]  persistence_sel, conversion_width, scale_sel;
    logic [15:0] lower_threshold, upper_threshold;
    logic [7:0]  wd [0:3];
    logic [7:0]  rq [0:9];
    logic        a;
    int          miscompares = 0;
    int          tests_run = 0;
    int          cycles = 0;
    // Wired-AND SDA with pull-up
    assign sda = (m_oe | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
    always #20 core_clk = ~core_clk;
    lsr_i2c_master lsr_i2c_master_inst (.scl(scl), .sda_oe(m_oe), .sda(sda));
    lsr_serial_port lsr_serial_port_inst (
        .core_clk(core_clk), .arst_n(arst_n), .scl_clk(scl), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .result_strobe(result_strobe), .result_value(result_value),
        .flag_raise(flag_raise), .mode_select(mode_select),
        .persistence_sel(persistence_sel), .conversion_width(conversion_width),
        .scale_sel(scale_sel), .lower_threshold(lower_threshold),
        .upper_threshold(upper_threshold), .flag_status(flag_status),
        .port_busy(port_busy));
    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Addressed and pointer bytes of a write frame
    task automatic head(input logic [7:0] ptr);
        lsr_i2c_master_inst.start();
        lsr_i2c_master_inst.wbyte(8'h88, a);
        chk(a, 1'b1);
        lsr_i2c_master_inst.wbyte(ptr, a);
        chk(a, 1'b1);
    endtask
    task automatic wr(input logic [7:0] ptr, input int n);
        head(ptr);
        for (int i = 0; i < n; i++) begin
            lsr_i2c_master_inst.wbyte(wd[i], a);
            chk(a, 1'b1);
        end
        lsr_i2c_master_inst.stop();
    endtask
    task automatic rd(input logic [7:0] ptr, input int n, input logic setp);
        if (setp) head(ptr);
        lsr_i2c_master_inst.start();
        lsr_i2c_master_inst.wbyte(8'h89, a);
        chk(a, 1'b1);
        for (int i = 0; i < n; i++) lsr_i2c_master_inst.rbyte(rq[i], i < n - 1);
        lsr_i2c_master_inst.stop();
    endtask
    task automatic idle_wait();
        for (int k = 0; k < 200 && port_busy !== 1'b0; k++) @(posedge core_clk);
        chk(port_busy, 1'b0);
    endtask
    // Frame that must go unanswered
    task automatic shunned(input logic [7:0] addr);
        lsr_i2c_master_inst.start();
        lsr_i2c_master_inst.wbyte(addr, a);
        lsr_i2c_master_inst.stop();
        chk(a, 1'b0);
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        shunned(8'h88);
        idle_wait();
        rd(8'h00, 10, 1'b1);
        for (int i = 0; i < 10; i++) chk(rq[i], lsr_pkg::REG_RESET[i % 9]);
        shunned(8'h8a);
        // Burst over the wrap, reserved bits written as zero
        wd = '{8'hab, 8'h5a, 8'he3, 8'h0f};
        wr(8'h07, 4);
        shunned(8'h88);
        idle_wait();
        chk(upper_threshold, 16'habff);
        chk({mode_select, persistence_sel, conversion_width, scale_sel}, 9'h1ff);
        rd(8'h00, 1, 1'b0);
        chk(rq[0], 8'h0f);
        rd(8'h08, 1, 1'b1);
        chk(rq[0], 8'h00);
        // STOP inside a data byte
        head(8'h04);
        for (int i = 0; i < 4; i++) lsr_i2c_master_inst.put_bit(1'b1);
        lsr_i2c_master_inst.stop();
        idle_wait();
        chk(lower_threshold, 16'h0000);
        // Result load and flag
        @(posedge core_clk);
        result_value <= 16'hbeef;
        result_strobe <= 1'b1;
        flag_raise <= 1'b1;
        @(posedge core_clk);
        result_strobe <= 1'b0;
        flag_raise <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(flag_status, 1'b1);
        rd(8'h02, 2, 1'b1);
        chk({rq[1], rq[0]}, 16'hbeef);
        rd(8'h00, 1, 1'b1);
        chk(rq[0], 8'he7);
        chk(flag_status, 1'b0);
        // Second reset restores defaults
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        shunned(8'h88);
        @(posedge core_clk);
        chk({mode_select, upper_threshold}, 19'h0ffff);
        arst_n <= 1'b1;
        idle_wait();
        rd(8'h01, 1, 1'b1);
        chk(rq[0], 8'h00);
        end_sim();
    end
endmodule
